// [dv/seep_host.sv]
// spi host model for the serial eeprom slave, mode 0, 64 ns serial clock
// assumes its pins are driven on falling edges of the system clock
`timescale 1ns/1ns
`default_nettype none
module seep_host (
    input  wire logic clock,  // system clock
    input  wire logic so_out, // slave output level
    input  wire logic so_oe,  // slave output enable
    output var  logic cs_n,   // chip select
    output var  logic sck,    // serial clock
    output var  logic si,     // serial data in
    output var  logic wp_n,   // write protect
    output var  logic hold_n  // pause
);
    logic last_so; // last driven so level
    logic so_line; // resolved so wire
    logic oe_any;  // so driven within select
    // a floated line shows the inverse of its last level
    always @(posedge clock) begin
        if (so_oe) last_so <= so_out;
    end
    assign so_line = so_oe ? so_out : ~last_so;
    // idle pins, clock stands low
    initial begin
        {cs_n, sck, si, wp_n, hold_n} = 5'h17;
        last_so = 1'b0;
        oe_any = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic select();
        cs_n = 1'b0;
        oe_any = 1'b0;
        tick(4);
    endtask
    task automatic deselect();
        sck = 1'b0;
        tick(4);
        cs_n = 1'b1;
        tick(8);
    endtask
    // one byte msb first; pause holds mid byte with a stray clock pulse
    task automatic xfer(input logic [7:0] tx, input bit pause, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            tick(4);
            if (pause && i == 3) begin
                hold_n = 1'b0;
                si = ~tx[i];
                tick(4);
                sck = 1'b1;
                tick(4);
                sck = 1'b0;
                si = tx[i];
                tick(4);
                hold_n = 1'b1;
                tick(4);
            end
            sck = 1'b1;
            tick(2);
            rx[i] = so_line;
            oe_any |= so_oe;
            tick(2);
        end
    endtask
endmodule // seep_host
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench of the serial eeprom slave driven by the host model
// assumes seep_slave and seep_host are compiled before it
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int WC = 400; // shortened write cycle
    logic       clock;
    logic       reset;
    logic       cs_n, sck, si, wp_n, hold_n;
    logic       so_out, so_oe, standby;
    int         err_count = 0;
    int         samples_checked = 0;
    logic [7:0] mem [256];   // expected array
    bit         known [256]; // byte written
    logic [1:0] lk = 2'h0;   // expected lock bits
    logic [7:0] rx;
    // clock generation
    initial clock = 1'b0;
    always #4 clock = ~clock;
    seep_slave #(.WRITE_CYCLES(WC)) uut (.clock(clock), .reset(reset), .cs_n_pin(cs_n),
        .sck_pin(sck), .si_pin(si), .wp_n_pin(wp_n), .hold_n_pin(hold_n),
        .so_out(so_out), .so_oe(so_oe), .standby(standby));
    seep_host host (.clock(clock), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n),
        .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    function automatic logic [7:0] stat(input logic lat);
        return {4'h0, lk, lat, 1'b0};
    endfunction
    function automatic bit locked(input logic [7:0] a);
        return lk == 2'h3 || (lk == 2'h2 && a[7]) || (lk == 2'h1 && a[7:6] == 2'h3);
    endfunction
    task automatic op(input logic [7:0] c);
        host.select();
        host.xfer(c, 1'b0, rx);
        host.deselect();
    endtask
    task automatic rd_status(input logic [7:0] exp, input bit pause);
        host.select();
        host.xfer(8'h05, 1'b0, rx);
        host.xfer(8'h00, pause, rx);
        host.deselect();
        chk(rx, exp);
    endtask
    // array write; same puts the latch command in the same select
    task automatic wr(input logic [7:0] a, input int n, input bit same, input bit wp_mid);
        logic [7:0] d [4];
        bit         ok;
        ok = !same && !wp_mid && n <= 4 && !locked(a);
        if (!same) op(8'h06);
        host.select();
        if (same) host.xfer(8'h06, 1'b0, rx);
        host.xfer(8'h02, 1'b0, rx);
        host.xfer(a, 1'b0, rx);
        if (wp_mid) host.wp_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            d[k % 4] = 8'($urandom);
            host.xfer(d[k % 4], 1'b0, rx);
        end
        host.deselect();
        host.wp_n = 1'b1;
        if (ok) begin
            chk({6'h0, so_oe, standby}, 8'h00);
            rd_status(8'hff, 1'b0);
            for (int k = 0; k < n; k++) begin
                mem[{a[7:2], 2'(a[1:0] + 2'(k))}] = d[k];
                known[{a[7:2], 2'(a[1:0] + 2'(k))}] = 1'b1;
            end
        end else if (!locked(a)) begin
            rd_status(stat(!wp_mid), 1'b0);
        end
        host.tick(WC + 100);
        if (ok) rd_status(stat(1'b0), 1'b0);
        op(8'h04);
        rd_status(stat(1'b0), 1'b0);
    endtask
    task automatic set_lock(input logic [1:0] l);
        op(8'h06);
        host.select();
        host.xfer(8'h01, 1'b0, rx);
        host.xfer({4'h0, l, 2'h0}, 1'b0, rx);
        host.deselect();
        rd_status(8'hff, 1'b0);
        host.tick(WC + 100);
        lk = l;
        rd_status(stat(1'b0), 1'b0);
    endtask
    task automatic rd_array(input logic [7:0] a, input int n);
        host.select();
        host.xfer(8'h03, 1'b0, rx);
        host.xfer(a, 1'b0, rx);
        for (int k = 0; k < n; k++) begin
            host.xfer(8'h00, k == 5, rx);
            if (known[8'(a + k)]) chk(rx, mem[8'(a + k)]);
        end
        host.deselect();
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        void'($urandom(32'h8786d389));
        reset = 1'b1;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        host.tick(4);
        rd_status(8'h00, 1'b0);
        op(8'h06);
        rd_status(8'h02, 1'b1);
        op(8'h04);
        rd_status(8'h00, 1'b0);
        host.select();
        host.xfer(8'h3c, 1'b0, rx);
        host.xfer(8'h05, 1'b0, rx);
        host.deselect();
        chk({7'h0, host.oe_any}, 8'h00);
        $display("test commands done");
        wr(8'hfe, 4, 1'b0, 1'b0);
        wr(8'h01, 4, 1'b0, 1'b0);
        wr(8'h41, 5, 1'b0, 1'b0);
        for (int i = 0; i < 10; i++) begin
            wr(8'($urandom), 1 + $urandom % 5, i == 3, i == 5);
        end
        $display("test writes done");
        for (int l = 4; l > 0; l--) begin
            set_lock(2'(l));
            wr(8'hc2, 2, 1'b0, 1'b0);
            wr(8'h83, 1, 1'b0, 1'b0);
            wr(8'h10, 3, 1'b0, 1'b0);
        end
        $display("test locks done");
        rd_array(8'hfe, 258);
        chk({6'h0, so_oe, standby}, 8'h01);
        $display("test read done");
        report_and_stop();
    end
    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge clock);
        err_count++;
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire

// [hdl/seep_pkg.sv]
// types of the serial eeprom slave
// assumes nothing beyond the compile order
package seep_pkg;

    // the five pins as sampled by the system clock
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
        logic hold_n;
    } seep_pins_t;

    // one write byte waiting for the nonvolatile cycle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } seep_wbyte_t;

    // position in the serial sequence of one select
    typedef enum logic [2:0] {
        PH_IGNORE,
        PH_OP,
        PH_RADDR,
        PH_WADDR,
        PH_WDATA,
        PH_RDATA,
        PH_STATUS_OUT,
        PH_STATUS_IN
    } seep_phase_t;

endpackage

// [hdl/seep_regs.svh]
// constants of the serial eeprom slave: opcodes, status layout, counts, timing
// assumes inclusion by bare name from the design file
`ifndef SEEP_REGS_SVH
`define SEEP_REGS_SVH

// instruction opcodes
`define SEEP_SET_WRITE_LATCH_CMD   8'h06
`define SEEP_CLEAR_WRITE_LATCH_CMD 8'h04
`define SEEP_READ_STATUS_CMD       8'h05
`define SEEP_WRITE_STATUS_CMD      8'h01
`define SEEP_READ_ARRAY_CMD        8'h03
`define SEEP_WRITE_ARRAY_CMD       8'h02

// protection_status field positions and values
`define SEEP_WRITE_BUSY_BIT        0
`define SEEP_WRITE_LATCH_BIT       1
`define SEEP_LOCK_RANGE_LOW_BIT    2
`define SEEP_LOCK_RANGE_HIGH_BIT   3
`define SEEP_STATUS_RESET          8'h00
`define SEEP_STATUS_BUSY_FILL      8'hff
`define SEEP_LOCK_RESET            2'h0

// first locked address for quarter and half protection
`define SEEP_LOCK_QUARTER_BASE     8'hc0
`define SEEP_LOCK_HALF_BASE        8'h80

// serial clock counts within one select
`define SEEP_OP_LAST_CNT           6'h07
`define SEEP_ADDR_LAST_CNT         6'h0f
`define SEEP_STATUS_WR_CNT         6'h10
`define SEEP_WR_CNT_MIN            6'h18
`define SEEP_WR_CNT_MAX            6'h30
`define SEEP_CNT_SAT               6'h3f

// timing
`define SEEP_CLK_PERIOD_NS         8
`define SEEP_WRITE_TIME_MS         5

// buffering and pin idle levels
`define SEEP_FIFO_DEPTH            16
`define SEEP_PIN_IDLE              5'h17

`endif

// [hdl/seep_slave.sv]
// serial eeprom slave: pin sampling, instruction sequencer, status, array, write timer
// assumes the five pins come asynchronous to clock and the far end drives the so wire
// Summary of operation
// R1 - opcode, address and data bits are taken on serial clock rising edges
// R2 - serial output changes after each falling serial clock edge
// R3 - deselect floats the output; standby unless a write cycle runs
// R4 - nothing is accepted before a first select falling edge after reset
// R5 - write protect low blocks nonvolatile writes, other functions stay
// R6 - protect falling during select aborts the write; a running cycle continues
// R7 - host moves hold only while the serial clock is low
// R8 - hold freezes the sequence; release continues from the same point
// R9 - eight bit instruction register, everything shifted most significant bit first
// R10 - host keeps select low, hold and protect high during an operation
// R11 - first instruction bit is the first rising edge after select falls
// R12 - a stopped serial clock keeps the transfer state
// R13 - writes complete only with the latch set; set and clear commands
// R14 - latch clears at reset, after any write cycle, and on protect low
// R15 - status read works at any time, also during a write cycle
// R16 - busy bit reads one during a write, while all bits read one
// R17 - latch bit reads the write enable latch
// R18 - four segments; lock bits protect none, top quarter, top half, all
// R19 - locked bytes read but never write; lock bits change by status write
// R20 - opcodes 06 set latch, 04 clear latch, 05 read status
// R21 - opcodes 01 write status, 03 read array, 02 write array
// R22 - 256 bytes of eight bits with an eight bit address
// R23 - accepted writes run a self timed cycle with busy set
// R24 - array read address increments per byte and wraps to zero
// R25 - write address wraps inside its four byte page
// R26 - array write starts only if select rises after clock 24, 32, 40, 48
// R27 - set latch needs its own select; a following write is ignored
// R28 - unknown opcodes are ignored with output floated until deselect
`timescale 1ns/1ns
`default_nettype none
`include "seep_regs.svh"

// small fifo with valid and ready on both sides
module seep_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = `SEEP_FIFO_DEPTH
) (
    input  wire logic             clock,     // system clock
    input  wire logic             reset,     // synchronous, active high
    input  wire logic             flush,     // drop all entries
    input  wire logic             in_valid,  // entry offered
    output var  logic             in_ready,  // room for an entry
    input  wire logic [WIDTH-1:0] in_data,   // entry offered
    output var  logic             out_valid, // entry waiting
    input  wire logic             out_ready, // drain side takes it
    output var  logic [WIDTH-1:0] out_data   // oldest entry
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      fill;
    logic             do_push;
    logic             do_pop;

    // honest full and empty from the fill count
    assign in_ready  = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data  = store[rd_ptr];
    assign do_push   = in_valid & in_ready;
    assign do_pop    = out_valid & out_ready;

    // pointers and fill
    always_ff @(posedge clock) begin
        if (reset || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                fill <= fill + 1'b1;
            end else if (do_pop && !do_push) begin
                fill <= fill - 1'b1;
            end
        end
    end

    // storage
    always_ff @(posedge clock) begin
        if (do_push) begin
            store[wr_ptr] <= in_data;
        end
    end
endmodule // seep_fifo

module seep_slave import seep_pkg::*; #(
    parameter int unsigned WRITE_CYCLES =
        `SEEP_WRITE_TIME_MS * 1000000 / `SEEP_CLK_PERIOD_NS
) (
    input  wire logic clock,      // system clock, 125 MHz
    input  wire logic reset,      // synchronous, active high
    input  wire logic cs_n_pin,   // chip select, active low
    input  wire logic sck_pin,    // serial clock
    input  wire logic si_pin,     // serial data in
    input  wire logic wp_n_pin,   // write protect, active low
    input  wire logic hold_n_pin, // pause, active low
    output var  logic so_out,     // serial data out level
    output var  logic so_oe,      // serial data out enable, high drives
    output var  logic standby     // low power standby indication
);
    localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);

    seep_pins_t  sync1;
    seep_pins_t  pin;
    seep_pins_t  prev;
    seep_phase_t phase;
    logic        active;
    logic [5:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  addr;
    logic [7:0]  out_byte;
    logic [2:0]  bidx;
    logic [7:0]  next_bit;
    logic        cs_fall;
    logic        cs_rise;
    logic        sck_rise;
    logic        sck_fall;
    logic        op_evt;
    logic        latch;
    logic        busy;
    logic [TW-1:0] timer;
    logic [1:0]  lock_bits;
    logic [1:0]  lock_new;
    logic        lock_pend;
    logic        drop;
    logic        push;
    logic        commit_arr;
    logic        commit_sts;
    logic        wr_cnt_ok;
    logic        reject;
    logic [7:0]  status_val;
    logic [7:0]  mem [256];
    seep_wbyte_t fifo_in;
    seep_wbyte_t fifo_out;
    logic        fifo_in_ready;
    logic        fifo_out_valid;

    // two flip-flop synchroniser, then one stage for edge finding
    always_ff @(posedge clock) begin
        if (reset) begin
            sync1 <= `SEEP_PIN_IDLE;
            pin   <= `SEEP_PIN_IDLE;
            prev  <= `SEEP_PIN_IDLE;
        end else begin
            sync1 <= {cs_n_pin, sck_pin, si_pin, wp_n_pin, hold_n_pin};
            pin   <= sync1;
            prev  <= pin;
        end
    end

    // edges; hold masks the serial clock without touching the sequence
    assign cs_fall  = prev.cs_n & ~pin.cs_n;
    assign cs_rise  = ~prev.cs_n & pin.cs_n;
    assign sck_rise = active & pin.hold_n & ~pin.cs_n & ~prev.sck & pin.sck; // R1 R8 R12
    assign sck_fall = active & pin.hold_n & ~pin.cs_n & prev.sck & ~pin.sck; // R2 R8
    assign next_bit = {sh[6:0], pin.si}; // R9
    assign op_evt   = sck_rise && (phase == PH_OP) && (cnt == `SEEP_OP_LAST_CNT);

    // status view: all ones while a cycle runs
    always_comb begin
        status_val = `SEEP_STATUS_RESET;
        status_val[`SEEP_WRITE_LATCH_BIT]     = latch; // R17
        status_val[`SEEP_LOCK_RANGE_LOW_BIT]  = lock_bits[0];
        status_val[`SEEP_LOCK_RANGE_HIGH_BIT] = lock_bits[1];
        if (busy) begin
            status_val = `SEEP_STATUS_BUSY_FILL; // R16
        end
    end

    // segment protection lookup
    function automatic logic seep_locked(input logic [7:0] a, input logic [1:0] bl);
        logic hit;
        hit = 1'b0;
        unique case (bl) // R18
            2'h0: hit = 1'b0;
            2'h1: hit = (a >= `SEEP_LOCK_QUARTER_BASE);
            2'h2: hit = (a >= `SEEP_LOCK_HALF_BASE);
            2'h3: hit = 1'b1;
        endcase
        return hit;
    endfunction

    // select tracking; nothing starts before a falling select edge
    always_ff @(posedge clock) begin
        if (reset) begin
            active <= 1'b0;
        end else if (cs_rise) begin
            active <= 1'b0;
        end else if (cs_fall) begin
            active <= 1'b1; // R4 R11
        end
    end

    // serial sequencer: bit count, instruction decode, address, output shifter
    always_ff @(posedge clock) begin
        if (reset) begin
            phase    <= PH_IGNORE;
            cnt      <= '0;
            sh       <= '0;
            addr     <= '0;
            out_byte <= '0;
            bidx     <= '0;
            so_out   <= 1'b0;
        end else if (cs_fall) begin
            phase <= PH_OP;
            cnt   <= '0; // R11
        end else if (cs_rise) begin
            phase <= PH_IGNORE;
        end else if (sck_rise) begin
            sh <= next_bit; // R1 R9
            if (cnt != `SEEP_CNT_SAT) begin
                cnt <= cnt + 6'h01;
            end
            unique case (phase)
                PH_OP: begin
                    if (cnt == `SEEP_OP_LAST_CNT) begin
                        bidx  <= '0;
                        phase <= PH_IGNORE; // R27 R28
                        if (next_bit == `SEEP_READ_STATUS_CMD) begin
                            phase    <= PH_STATUS_OUT; // R15 R20
                            out_byte <= status_val;
                        end else if (!busy) begin
                            if (next_bit == `SEEP_WRITE_STATUS_CMD) begin
                                phase <= PH_STATUS_IN; // R21
                            end else if (next_bit == `SEEP_READ_ARRAY_CMD) begin
                                phase <= PH_RADDR; // R21
                            end else if (next_bit == `SEEP_WRITE_ARRAY_CMD) begin
                                phase <= PH_WADDR; // R21
                            end
                        end
                    end
                end
                PH_RADDR: begin
                    if (cnt == `SEEP_ADDR_LAST_CNT) begin
                        addr     <= next_bit; // R22
                        out_byte <= mem[next_bit];
                        bidx     <= '0;
                        phase    <= PH_RDATA;
                    end
                end
                PH_WADDR: begin
                    if (cnt == `SEEP_ADDR_LAST_CNT) begin
                        addr  <= next_bit;
                        phase <= PH_WDATA;
                    end
                end
                PH_WDATA: begin
                    if (cnt[2:0] == 3'h7) begin
                        addr[1:0] <= addr[1:0] + 2'h1; // R25
                    end
                end
                PH_IGNORE, PH_RDATA, PH_STATUS_OUT, PH_STATUS_IN: begin // nothing to take
                end
            endcase
        end else if (sck_fall && (phase == PH_RDATA || phase == PH_STATUS_OUT)) begin
            so_out   <= out_byte[7]; // R2 R9
            out_byte <= {out_byte[6:0], 1'b0};
            bidx     <= bidx + 3'h1;
            if (bidx == 3'h7) begin
                if (phase == PH_RDATA) begin
                    addr     <= addr + 8'h01; // R24
                    out_byte <= mem[addr + 8'h01];
                end else begin
                    out_byte <= status_val; // R15
                end
            end
        end
    end

    // output enable only while selected, unpaused and sending
    always_ff @(posedge clock) begin
        if (reset) begin
            so_oe <= 1'b0;
        end else begin
            so_oe <= active & ~pin.cs_n & pin.hold_n &
                     ((phase == PH_RDATA) || (phase == PH_STATUS_OUT)); // R3 R8 R28
        end
    end

    // standby while deselected and idle
    always_ff @(posedge clock) begin
        if (reset) begin
            standby <= 1'b1;
        end else begin
            standby <= ~active & ~busy; // R3
        end
    end

    // write bytes into the buffer; overflow or protect low spoils the select
    assign push    = sck_rise && (phase == PH_WDATA) && (cnt[2:0] == 3'h7);
    assign fifo_in = '{addr: addr, data: next_bit};

    always_ff @(posedge clock) begin
        if (reset || cs_fall) begin
            drop <= 1'b0;
        end else if ((push && !fifo_in_ready) || (active && !pin.wp_n)) begin
            drop <= 1'b1; // R6
        end
    end

    // acceptance at the rising select edge
    assign wr_cnt_ok  = (cnt >= `SEEP_WR_CNT_MIN) && (cnt <= `SEEP_WR_CNT_MAX) &&
                        (cnt[2:0] == 3'h0);
    assign commit_arr = cs_rise && active && (phase == PH_WDATA) && wr_cnt_ok &&
                        latch && pin.wp_n && !drop && !busy; // R5 R13 R26
    assign commit_sts = cs_rise && active && (phase == PH_STATUS_IN) &&
                        (cnt == `SEEP_STATUS_WR_CNT) &&
                        latch && pin.wp_n && !drop && !busy; // R5 R13 R19
    assign reject     = cs_rise && active && (phase == PH_WDATA) && !commit_arr; // R26

    seep_fifo #(
        .WIDTH ($bits(seep_wbyte_t)),
        .DEPTH (`SEEP_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .flush     (reject),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (busy),
        .out_data  (fifo_out)
    );

    // self timed nonvolatile cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            busy  <= 1'b0;
            timer <= '0;
        end else if (commit_arr || commit_sts) begin
            busy  <= 1'b1; // R23
            timer <= TW'(WRITE_CYCLES - 1);
        end else if (busy) begin
            if (timer == '0) begin
                busy <= 1'b0;
            end else begin
                timer <= timer - 1'b1;
            end
        end
    end

    // lock bits: taken at the status write, applied at the end of its cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            lock_bits <= `SEEP_LOCK_RESET;
            lock_new  <= `SEEP_LOCK_RESET;
            lock_pend <= 1'b0;
        end else begin
            if (sck_rise && (phase == PH_STATUS_IN) && (cnt == `SEEP_ADDR_LAST_CNT)) begin
                lock_new <= {next_bit[`SEEP_LOCK_RANGE_HIGH_BIT],
                             next_bit[`SEEP_LOCK_RANGE_LOW_BIT]};
            end
            if (commit_sts) begin
                lock_pend <= 1'b1;
            end else if (busy && timer == '0) begin
                lock_pend <= 1'b0;
                if (lock_pend) begin
                    lock_bits <= lock_new; // R19
                end
            end
        end
    end

    // write enable latch
    always_ff @(posedge clock) begin
        if (reset) begin
            latch <= 1'b0; // R14
        end else if (!pin.wp_n || (busy && timer == '0)) begin
            latch <= 1'b0; // R14
        end else if (op_evt && !busy && next_bit == `SEEP_CLEAR_WRITE_LATCH_CMD) begin
            latch <= 1'b0; // R13 R20
        end else if (op_evt && !busy && next_bit == `SEEP_SET_WRITE_LATCH_CMD) begin
            latch <= 1'b1; // R13 R20
        end
    end

    // array update while the cycle drains the buffer; locked bytes refused
    always_ff @(posedge clock) begin
        if (busy && fifo_out_valid && !seep_locked(fifo_out.addr, lock_bits)) begin
            mem[fifo_out.addr] <= fifo_out.data; // R19 R22
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_set_cmd;
        op_evt && !busy && pin.wp_n && next_bit == `SEEP_SET_WRITE_LATCH_CMD;
    endsequence
    sequence s_select_end;
        cs_rise && active;
    endsequence

    // set command raises the latch and status shows it
    property p_set_latch;
        s_set_cmd |=> latch && status_val[`SEEP_WRITE_LATCH_BIT];
    endproperty
    a_set_latch: assert property (p_set_latch) else $error("latch not set"); // R13

    // protect low drops the latch
    property p_wp_clears;
        !pin.wp_n |=> !latch;
    endproperty
    a_wp_clears: assert property (p_wp_clears) else $error("latch kept on protect"); // R14

    // deselect floats the output within two cycles
    property p_float;
        s_select_end |-> ##[1:2] !so_oe;
    endproperty
    a_float: assert property (p_float) else $error("output driven while deselected"); // R3

    // paused clock edges leave the sequence alone
    property p_hold;
        (!pin.hold_n && !prev.sck && pin.sck) |=> $stable(cnt) && $stable(sh);
    endproperty
    a_hold: assert property (p_hold) else $error("sequence moved during hold"); // R8

    // no bit is taken before a select falling edge
    property p_no_early;
        (!active && !cs_fall) |=> $stable(cnt);
    endproperty
    a_no_early: assert property (p_no_early) else $error("bit taken while unselected"); // R4

    // an accepted write keeps busy for a stretch and reads all ones
    property p_busy_run;
        $rose(busy) |-> (busy && status_val == `SEEP_STATUS_BUSY_FILL) [*4];
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("busy cycle too short"); // R16 R23

    // wrong clock count never starts a cycle
    property p_bad_count;
        (s_select_end and (phase == PH_WDATA && !wr_cnt_ok && !busy)) |=> !busy;
    endproperty
    a_bad_count: assert property (p_bad_count) else $error("write at bad count"); // R26

    // read wraps from the top address to zero
    property p_read_wrap;
        (sck_fall && phase == PH_RDATA && bidx == 3'h7 && addr == 8'hff) |=> addr == 8'h00;
    endproperty
    a_read_wrap: assert property (p_read_wrap) else $error("read address no wrap"); // R24

    // write address stays in its page
    property p_page_wrap;
        push |=> addr[7:2] == $past(addr[7:2]);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("write left its page"); // R25

    // protect low at the select end blocks the write
    property p_wp_block;
        (s_select_end and (!pin.wp_n && !busy)) |=> !busy;
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("write under protect"); // R5
endmodule // seep_slave

`default_nettype wire
